// ---- src/jlst_defines.vh ----
// constants for the multiframe alignment and sync timing block
`ifndef JLST_DEFINES_VH
`define JLST_DEFINES_VH
// sysref latch to internal multiframe boundary, device clock periods
`define JLST_SYSREF_TO_BOUNDARY   40
// boundary to next transmitted multiframe, tenths of device clock periods
`define JLST_TX_DELAY_D32_P54_X10 515
`define JLST_TX_DELAY_D16_DDR_P54_X10 439
`define JLST_TX_DELAY_DEFAULT_X10 527
// whole cycles, the tenths values above rounded down; the half cycle is flagged separately
`define JLST_TX_DELAY_D32_P54     7'd51
`define JLST_TX_DELAY_D16_DDR_P54 7'd43
`define JLST_TX_DELAY_DEFAULT     7'd52
// sync request: least assertion in frame clock cycles
`define JLST_SYNC_MIN_FRAMES      4
// lane alignment sequence length in multiframes
`define JLST_ILA_MULTIFRAMES      4
// decimation mode codes
`define JLST_DECIM_16             6'h10
`define JLST_DECIM_32             6'h20
`endif

// ---- src/jlst_fifo.v ----
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module jlst_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             rst_b,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr;
   reg [AW-1:0]    rdPtr;
   reg [AW:0]      count;
   wire            doWr = inValid && inReady;
   wire            doRd = outValid && outReady;
   assign inReady  = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   always @* begin
      outData = mem[rdPtr];
   end
   always @(posedge core_clk) begin
      if (!rst_b) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            mem[wrPtr] <= inData;
            wrPtr      <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
         end
         if (doRd)
            rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
         if (doWr && !doRd)
            count <= count + 1'b1;
         else if (doRd && !doWr)
            count <= count - 1'b1;
      end
   end
endmodule // jlst_fifo

// ---- src/jlst_align.v ----
// multiframe boundary, transmit framing and sync request handling
`timescale 1ns/1ps
`include "jlst_defines.vh"
// ==========================================
module jlst_align #(
   parameter MF_LEN    = 10'd320,
   parameter FRAME_LEN = 10'd4,
   parameter DW        = 16,
   parameter DEPTH     = 8
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          rst_b,
   // mode straps
   input  wire [5:0]    decimation,
   input  wire          doubleRate,
   input  wire          alternate_packing_option,
   // link pins
   input  wire          sysref,
   input  wire          syncReq_b,
   // sample input
   input  wire          smpValid,
   output wire          smpReady,
   input  wire [DW-1:0] smpData,
   // link output
   output reg           boundary,
   output reg           mfStart,
   output reg           halfCycle,
   output reg           ilaActive,
   output reg           txValid,
   output reg  [DW-1:0] txData,
   output reg  [1:0]    linkState
);
   localparam ST_SYNC = 4'b0001;
   localparam ST_WAIT = 4'b0010;
   localparam ST_ILA  = 4'b0100;
   localparam ST_DATA = 4'b1000;
   // ==========================================
   // input synchronisers
   reg  sysMeta, sysSync, sysLast;
   reg  synMeta, synSync;
   always @(posedge core_clk) begin
      if (!rst_b) begin
         sysMeta <= 1'b0;
         sysSync <= 1'b0;
         sysLast <= 1'b0;
         synMeta <= 1'b1;
         synSync <= 1'b1;
      end else begin
         sysMeta <= sysref;
         sysSync <= sysMeta;
         sysLast <= sysSync;
         synMeta <= syncReq_b;
         synSync <= synMeta;
      end
   end
   // sysref pulse shape is the source's duty; rising edges only are used here
   wire sysRise = sysSync && !sysLast;
   // ==========================================
   // boundary placement
   reg  [5:0] sysDly;
   reg        sysArmed;
   reg  [9:0] mfCount;
   reg  [9:0] frmCount;
   wire       phaseLoad = sysArmed && (sysDly == 6'h01);
   always @(posedge core_clk) begin
      if (!rst_b) begin
         sysDly   <= 6'h00;
         sysArmed <= 1'b0;
         mfCount  <= 10'h000;
         frmCount <= 10'h000;
         boundary <= 1'b0;
      end else begin
         boundary <= 1'b0;
         if (sysRise) begin
            // synchroniser stages count toward the 40-clock delay
            sysArmed <= 1'b1;
            sysDly   <= 6'd`JLST_SYSREF_TO_BOUNDARY - 6'h02;
         end else if (sysArmed && sysDly != 6'h00)
            sysDly <= sysDly - 1'b1;
         if (phaseLoad) begin
            // a fresh sysref edge in the load cycle keeps the delay armed
            sysArmed <= sysRise;
            mfCount  <= 10'h000;
            frmCount <= 10'h000;
            boundary <= 1'b1;
         end else begin
            mfCount  <= (mfCount == MF_LEN - 1'b1) ? 10'h000 : mfCount + 1'b1;
            frmCount <= (frmCount == FRAME_LEN - 1'b1) ? 10'h000 : frmCount + 1'b1;
            if (mfCount == MF_LEN - 1'b1)
               boundary <= 1'b1;
         end
      end
   end
   wire frameTick = (frmCount == FRAME_LEN - 1'b1);
   // ==========================================
   // transmit multiframe offset
   reg [6:0] txDelay;
   reg       txHalf;
   always @* begin
      txHalf = 1'b0;
      if (decimation == `JLST_DECIM_32 && !doubleRate && alternate_packing_option) begin
         txDelay = `JLST_TX_DELAY_D32_P54;
         txHalf  = 1'b1;
      end else if (decimation == `JLST_DECIM_16 && doubleRate && alternate_packing_option)
         txDelay = `JLST_TX_DELAY_D16_DDR_P54;
      else
         txDelay = `JLST_TX_DELAY_DEFAULT;
   end
   reg [6:0] txCnt;
   reg       txRun;
   reg       txHalfHeld;
   always @(posedge core_clk) begin
      if (!rst_b) begin
         txCnt      <= 7'h00;
         txRun      <= 1'b0;
         txHalfHeld <= 1'b0;
         mfStart    <= 1'b0;
         halfCycle  <= 1'b0;
      end else begin
         mfStart <= 1'b0;
         if (boundary) begin
            txRun      <= 1'b1;
            // boundary is already one edge old here, so two come off the count
            txCnt      <= txDelay - 7'h02;
            // the mode is taken at the boundary, a strap change in flight waits
            txHalfHeld <= txHalf;
         end else if (txRun) begin
            if (txCnt == 7'h00) begin
               // functional delay exact; serialiser lag is outside this block
               mfStart   <= 1'b1;
               halfCycle <= txHalfHeld;
               txRun     <= 1'b0;
            end else
               txCnt <= txCnt - 1'b1;
         end
      end
   end
   // ==========================================
   // sync request filter and link sequence
   reg [3:0] syncFrames;
   reg       syncLong;
   reg [3:0] state;
   reg [2:0] ilaCount;
   // a late sync edge is just taken at the next boundary
   always @(posedge core_clk) begin
      if (!rst_b) begin
         syncFrames <= 4'h0;
         syncLong   <= 1'b0;
         state      <= ST_SYNC;
         ilaCount   <= 3'h0;
      end else begin
         if (synSync) begin
            syncFrames <= 4'h0;
            syncLong   <= 1'b0;
         end else if (frameTick && syncFrames != 4'hf)
            syncFrames <= syncFrames + 1'b1;
         // the tick that completes the count is taken at once, so a low of exactly
         // four frames counts whatever its phase against the frame ticks
         if (!synSync && (syncFrames >= `JLST_SYNC_MIN_FRAMES ||
                          (frameTick && syncFrames == `JLST_SYNC_MIN_FRAMES - 1)))
            syncLong <= 1'b1;
         case (state)
            ST_SYNC: begin
               if (synSync && syncLong)
                  state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (boundary) begin
                  state    <= ST_ILA;
                  ilaCount <= 3'h0;
               end
            end
            ST_ILA: begin
               if (boundary) begin
                  if (ilaCount == `JLST_ILA_MULTIFRAMES - 1)
                     state <= ST_DATA;
                  else
                     ilaCount <= ilaCount + 1'b1;
               end
            end
            ST_DATA: begin
               // short pulses leave the link running
               if (synSync && syncLong)
                  state <= ST_WAIT;
            end
            default: state <= ST_SYNC;
         endcase
      end
   end
   // ==========================================
   // sample buffer and output
   wire          fifoValid;
   wire [DW-1:0] fifoData;
   wire          drain = (state == ST_DATA);
   jlst_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(3)) uFifo (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .inValid  (smpValid),
      .inReady  (smpReady),
      .inData   (smpData),
      .outValid (fifoValid),
      .outReady (drain),
      .outData  (fifoData)
   );
   always @(posedge core_clk) begin
      if (!rst_b) begin
         txValid   <= 1'b0;
         txData    <= {DW{1'b0}};
         ilaActive <= 1'b0;
         linkState <= 2'h0;
      end else begin
         txValid   <= drain && fifoValid;
         txData    <= (drain && fifoValid) ? fifoData : {DW{1'b0}};
         ilaActive <= (state == ST_ILA);
         linkState <= {state[3] | state[2], state[3] | state[1]};
      end
   end
endmodule // jlst_align

// ---- tb/jlst_align_asserts.sv ----
// checker for boundary, framing and lane alignment timing
`timescale 1ns/1ps
`include "jlst_defines.vh"
module jlst_align_asserts #(parameter int MF_LEN = 80) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_b,
   // straps and pins
   input wire logic [5:0] decimation,
   input wire logic       doubleRate,
   input wire logic       alternate_packing_option,
   input wire logic       sysref,
   // link outputs
   input wire logic       boundary,
   input wire logic       mfStart,
   input wire logic       halfCycle,
   input wire logic       ilaActive,
   input wire logic       txValid,
   input wire logic [1:0] linkState
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [2:0] ilaB;
   wire ap = alternate_packing_option;
   wire m32 = decimation == `JLST_DECIM_32 && !doubleRate && ap;
   wire m16 = decimation == `JLST_DECIM_16 && doubleRate && ap;
   // boundaries seen while alignment runs; cleared outside it
   always @(posedge core_clk) ilaB <= ilaActive ? ilaB + {2'b0, boundary} : 3'd0;
   // boundary is set by the 40th edge after the pin sample and read one edge later
   sysref_boundary_a: assert property ($rose(sysref) |-> ##41 boundary)
      else $error("boundary not 40 cycles after sysref");
   boundary_period_a: assert property (boundary |-> ##MF_LEN boundary)
      else $error("boundary period wrong");
   d32_delay_a: assert property (boundary && m32 |-> ##51 mfStart && halfCycle)
      else $error("decimation 32 frame start wrong");
   d16_delay_a: assert property (boundary && m16 |-> ##43 mfStart && !halfCycle)
      else $error("decimation 16 frame start wrong");
   other_delay_a: assert property (boundary && !m32 && !m16 |-> ##52 mfStart)
      else $error("default frame start wrong");
   ila_start_a: assert property ($rose(ilaActive) |-> $past(boundary, 2))
      else $error("alignment began off a boundary");
   ila_length_a: assert property ($fell(ilaActive) |-> ilaB == 3'd4 && linkState == 2'd3)
      else $error("alignment length wrong");
   data_only_a: assert property (txValid |-> linkState == 2'd3 && !ilaActive)
      else $error("data sent outside data state");
   cover property ($fell(ilaActive));
   cover property (boundary && m16);
   cover property (txValid);
endmodule // jlst_align_asserts
bind jlst_align jlst_align_asserts #(.MF_LEN(MF_LEN)) chk (
   .core_clk                 (core_clk),
   .rst_b                    (rst_b),
   .decimation               (decimation),
   .doubleRate               (doubleRate),
   .alternate_packing_option (alternate_packing_option),
   .sysref                   (sysref),
   .boundary                 (boundary),
   .mfStart                  (mfStart),
   .halfCycle                (halfCycle),
   .ilaActive                (ilaActive),
   .txValid                  (txValid),
   .linkState                (linkState)
);

// ---- tb/jlst_peer.sv ----
// receiver and sysref source facing the alignment block
`timescale 1ns/1ps
module jlst_peer #(parameter int FRAME_LEN = 4) (
   // clock and boundary
   input wire logic core_clk,
   input wire logic boundary,
   // link pins
   output logic     sysref = 1'b0,
   output logic     syncReq_b = 1'b1
);
   // set when a wait for a boundary runs out; the bench counts it as a mismatch
   logic waitExpired = 1'b0;
   task automatic pulseSysref();
      sysref <= 1'b1;
      repeat (8) @(posedge core_clk);
      sysref <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   // moves sync just after a boundary, clear of the next setup and hold windows
   task automatic requestSync(input int frames);
      int n;
      n = 0;
      while (boundary !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 400)
         waitExpired = 1'b1;
      @(posedge core_clk);
      syncReq_b <= 1'b0;
      repeat (frames * FRAME_LEN) @(posedge core_clk);
      syncReq_b <= 1'b1;
   endtask
endmodule // jlst_peer

// ---- tb/tb_jlst_align.sv ----
// self-checking bench for the alignment block
`timescale 1ns/1ps
`include "jlst_defines.vh"
module tb_jlst_align;
   logic        core_clk = 0, rst_b = 0, doubleRate = 0, smpValid = 0;
   logic        alternate_packing_option = 1;
   logic [5:0]  decimation = `JLST_DECIM_32;
   logic [15:0] smpData = 0, txData;
   logic        smpReady, boundary, mfStart, halfCycle, ilaActive, txValid;
   logic        sysref, syncReq_b;
   logic [1:0]  linkState;
   logic [31:0] lfsr = 32'h1b7eeac7;
   logic [15:0] expQ[$];
   int          fail_count = 0, samples_checked = 0, acc;
   always #2.5 core_clk = ~core_clk;
   jlst_align #(.MF_LEN(10'd80), .FRAME_LEN(10'd4)) dut (
      .core_clk                 (core_clk),
      .rst_b                    (rst_b),
      .decimation               (decimation),
      .doubleRate               (doubleRate),
      .alternate_packing_option (alternate_packing_option),
      .sysref                   (sysref),
      .syncReq_b                (syncReq_b),
      .smpValid                 (smpValid),
      .smpReady                 (smpReady),
      .smpData                  (smpData),
      .boundary                 (boundary),
      .mfStart                  (mfStart),
      .halfCycle                (halfCycle),
      .ilaActive                (ilaActive),
      .txValid                  (txValid),
      .txData                   (txData),
      .linkState                (linkState)
   );
   jlst_peer #(.FRAME_LEN(4)) peer (
      .core_clk  (core_clk),
      .boundary  (boundary),
      .sysref    (sysref),
      .syncReq_b (syncReq_b)
   );
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic checkWord(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic checkState(input logic [1:0] exp);
      checkWord({14'h0, linkState}, {14'h0, exp});
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // w=0 waits for a frame start, w=1 for the data state
   task automatic waitFor(input int w);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((w ? linkState !== 2'd3 : mfStart !== 1'b1) && n < 1000);
      if (n >= 1000) begin
         fail_count++;
         finish_test();
      end
   endtask
   // a partner wait that runs out ends the run as a mismatch
   task automatic syncRequest(input int frames);
      peer.requestSync(frames);
      if (peer.waitExpired) begin
         fail_count++;
         finish_test();
      end
   endtask
   // offers random words for k cycles, a new one only after each is taken, notes each one taken
   task automatic feed(input int k);
      acc = 0;
      lfsr = nextRand(lfsr);
      smpValid <= 1'b1;
      smpData <= lfsr[15:0];
      repeat (k) begin
         @(posedge core_clk);
         if (smpReady === 1'b1) begin
            expQ.push_back(smpData);
            acc++;
            lfsr = nextRand(lfsr);
            smpData <= lfsr[15:0];
         end
      end
      smpValid <= 1'b0;
   endtask
   always @(posedge core_clk)
      if (txValid === 1'b1)
         checkWord(txData, expQ.size() ? expQ.pop_front() : ~txData);
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      peer.pulseSysref();
      waitFor(0);
      {decimation, doubleRate} <= {`JLST_DECIM_16, 1'b1};
      waitFor(0);
      alternate_packing_option <= 1'b0;
      doubleRate <= 1'b0;
      $display("frame placement modes done");
      feed(12);
      checkWord(acc[15:0], 16'h8);
      syncRequest(3);
      repeat (12) @(posedge core_clk);
      checkState(2'd0);
      syncRequest(4);
      repeat (12) @(posedge core_clk);
      checkState(2'd1);
      waitFor(1);
      checkState(2'd3);
      feed(12);
      repeat (40) @(posedge core_clk);
      checkWord(16'(expQ.size()), 16'h0);
      $display("fill, sync and drain done");
      syncRequest(4);
      repeat (12) @(posedge core_clk);
      checkState(2'd1);
      waitFor(1);
      checkState(2'd3);
      $display("resync done");
      finish_test();
   end
endmodule // tb_jlst_align
